/* core/td_pkg.sv */
// Purpose: Shared constants and types for the touch detect processing core.
// Assumes: 100 MHz system clock, one clock domain.
// Notes:   All times are kept in their own unit; cycle counts derive from them.
`default_nettype none
package td_pkg;
   // Clock and time base
   localparam int CLK_PERIOD_NS  = 10;
   localparam int TICK_NS        = 1000000;                 // 1 ms time base
   localparam int TICK_CYC       = TICK_NS / CLK_PERIOD_NS; // cycles per ms tick

   // Burst spacing and output timing, in ms
   localparam logic [15:0] BURST_IDLE_MS  = 16'd75;
   localparam logic [15:0] BURST_CONF_MS  = 16'd20;
   localparam logic [6:0]  PULSE_MS       = 7'd75;
   localparam logic [15:0] MAXON_SHORT_MS = 16'd10000;
   localparam logic [15:0] MAXON_LONG_MS  = 16'd60000;

   // Detection integrator
   localparam logic [2:0]  INTEG_LIMIT    = 3'd4;

   // Drift compensation: one count per step, rise only every N bursts
   localparam logic [15:0] DRIFT_STEP     = 16'h0001;
   localparam logic [5:0]  DRIFT_UP_BURST = 6'd16;

   // Threshold fraction of the reference, in 1/256 units, per gain level
   localparam logic [7:0]  FRAC_GAIN_HI   = 8'h04;
   localparam logic [7:0]  FRAC_GAIN_MED  = 8'h08;
   localparam logic [7:0]  FRAC_GAIN_LO   = 8'h10;

   // Gain strap codes; open pin reads as 2'b00
   localparam logic [1:0]  GAIN_OPEN      = 2'h0;
   localparam logic [1:0]  GAIN_MED       = 2'h1;
   localparam logic [1:0]  GAIN_LO        = 2'h2;

   // Register map, byte offsets
   localparam logic [7:0]  REG_CTRL       = 8'h00;
   localparam logic [7:0]  REG_STATUS     = 8'h04;
   localparam logic [7:0]  REG_RAW        = 8'h08;
   localparam logic [7:0]  REG_REF        = 8'h0c;
   localparam logic [7:0]  REG_THR        = 8'h10;
   localparam int          CTRL_RUN_BIT   = 0;
   localparam logic        CTRL_RUN_RST   = 1'b1;

   // Output modes taken from the two mode straps {a,b}
   typedef enum logic [1:0] {
      TD_MODE_TOGGLE = 2'b00,
      TD_MODE_PULSE  = 2'b01,
      TD_MODE_DC60   = 2'b10,
      TD_MODE_DC10   = 2'b11
   } td_mode_t;

   typedef enum logic [1:0] {
      TD_ST_STRAP,
      TD_ST_WAIT,
      TD_ST_ACQ
   } td_st_t;
endpackage
`default_nettype wire

/* core/td_thr_if.sv */
// Purpose: Carries reference, sample and threshold results between core and compare.
// Assumes: Purely combinational exchange within one clock domain.
// Notes:   Core drives ref, raw and gain; the compare unit returns the levels and flags.
`default_nettype none
interface td_thr_if;
   logic [15:0] ref_lvl;
   logic [15:0] raw;
   logic [1:0]  gain;
   logic [15:0] thr_lvl;
   logic [15:0] hyst_lvl;
   logic        qual;
   logic        hold;
   modport core (output ref_lvl, raw, gain, input thr_lvl, hyst_lvl, qual, hold);
   modport calc (input ref_lvl, raw, gain, output thr_lvl, hyst_lvl, qual, hold);
endinterface
`default_nettype wire

/* core/td_thresh.sv */
// Purpose: Threshold and hysteresis levels and the per-burst compare result.
// Assumes: Levels follow the reference combinationally, so they never lag it.
// Notes:   Sums saturate at full scale to keep a high reference from wrapping.
`default_nettype none
module td_thresh
   import td_pkg::*;
(
   td_thr_if.calc t
);
   logic [7:0]  frac;
   logic [23:0] prod;
   logic [15:0] delta;
   logic [16:0] thr_sum;
   logic [16:0] hyst_sum;

   // Gain sets the fraction; open strap gives the smallest one, the highest gain
   always_comb begin
      case (t.gain)
         GAIN_MED: frac = FRAC_GAIN_MED;
         GAIN_LO:  frac = FRAC_GAIN_LO;
         default:  frac = FRAC_GAIN_HI;
      endcase
   end

   // Differential is a share of the absolute level, recomputed every cycle
   assign prod     = t.ref_lvl * frac;
   assign delta    = prod[23:8];
   assign thr_sum  = {1'b0, t.ref_lvl} + {1'b0, delta};
   assign hyst_sum = {1'b0, t.ref_lvl} + {2'b00, delta[15:1]};
   assign t.thr_lvl  = thr_sum[16]  ? 16'hffff : thr_sum[15:0];
   assign t.hyst_lvl = hyst_sum[16] ? 16'hffff : hyst_sum[15:0];

   // One qualifying flag per burst; hold keeps a detection down to the dropout level
   assign t.qual = t.raw > t.thr_lvl;
   assign t.hold = t.raw >= t.hyst_lvl;
endmodule
`default_nettype wire

/* core/td_core.sv */
// Purpose: Burst scheduling, drift tracking, integrator, max on-duration and output.
// Assumes: Converter answers each burst request with one raw_valid_i pulse.
// Notes:   Straps are read once after reset; no recalibration input exists.
//
// Decided for this implementation: the register addresses and the strobed register port.
`default_nettype none
module td_core
   import td_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)(
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   // Strap inputs
   input  wire logic [1:0]  gain_strap_i,
   input  wire logic        mode_strap_a_i,
   input  wire logic        mode_strap_b_i,
   // Converter side
   output logic             burst_req_o,
   input  wire logic        raw_valid_i,
   input  wire logic [15:0] raw_i,
   // Register port
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [31:0]      rdata_o,
   // Output line, active low, and detection flag, active high
   output logic             out_n_o,
   output logic             detect_o
);
   typedef struct packed {
      td_st_t      st;
      logic [16:0] tick_cnt;
      logic [15:0] wait_ms;
      logic [15:0] on_ms;
      logic [6:0]  pulse_ms;
      logic [15:0] ref_lvl;
      logic [15:0] raw;
      logic [2:0]  integ;
      logic [5:0]  drift_cnt;
      logic        det;
      logic        out_lvl;
      logic        out_n;
      logic        cal;
      logic [1:0]  gain;
      td_mode_t    mode;
      logic        run;
      logic [31:0] rdata;
   } td_state_t;

   td_state_t s_q;
   td_state_t s_d;
   logic      tick;
   logic      acq_done;
   logic      timeout;
   logic      new_det;
   logic      end_det;
   logic      fire;
   logic [15:0] maxon_ms;

   td_thr_if thr_if ();

   // Threshold and compare unit
   td_thresh u_thresh (
      .t (thr_if.calc)
   );

   assign thr_if.ref_lvl = s_q.ref_lvl;
   assign thr_if.raw     = raw_i;
   assign thr_if.gain    = s_q.gain;

   // Millisecond enable from the clock divider
   assign tick = s_q.tick_cnt == 17'(TICK_CYCLES - 1);

   // Burst request fires when spacing elapsed; handshake is combinational
   assign fire        = (s_q.st == TD_ST_WAIT) && (s_q.wait_ms == 16'h0000) && s_q.run;
   assign burst_req_o = fire;
   assign acq_done    = (s_q.st == TD_ST_ACQ) && raw_valid_i;

   // Limit comes from the strapped mode; only one level mode gets the long one
   assign maxon_ms = (s_q.mode == TD_MODE_DC60) ? MAXON_LONG_MS : MAXON_SHORT_MS;
   assign timeout  = s_q.det && tick && (s_q.on_ms >= maxon_ms - 16'h0001);

   // Detection edges seen by this burst, outside a recalibration burst
   assign new_det = acq_done && !s_q.cal && !s_q.det && thr_if.qual &&
                    (s_q.integ == INTEG_LIMIT - 3'd1);
   assign end_det = acq_done && !s_q.cal && s_q.det && !thr_if.hold;

   // Next state
   always_comb begin
      s_d = s_q;

      // Divider runs freely; every slower rate uses its enable
      s_d.tick_cnt = tick ? 17'h00000 : s_q.tick_cnt + 17'h00001;

      // Straps are caught once, in the first cycle after reset release
      if (s_q.st == TD_ST_STRAP) begin
         s_d.gain = gain_strap_i;
         s_d.mode = td_mode_t'({mode_strap_a_i, mode_strap_b_i});
         s_d.st   = TD_ST_WAIT;
      end

      // Spacing countdown in ms
      if (tick && s_q.wait_ms != 16'h0000) begin
         s_d.wait_ms = s_q.wait_ms - 16'h0001;
      end

      if (fire) begin
         s_d.st = TD_ST_ACQ;
      end

      // Pulse timer for the pulse output mode
      if (tick && s_q.pulse_ms != 7'h00) begin
         s_d.pulse_ms = s_q.pulse_ms - 7'h01;
      end

      // On-duration timer only counts while detecting
      if (s_q.det && tick) begin
         s_d.on_ms = s_q.on_ms + 16'h0001;
      end

      // Burst result handling
      if (acq_done) begin
         s_d.st  = TD_ST_WAIT;
         s_d.raw = raw_i;
         s_d.wait_ms = BURST_IDLE_MS;
         if (s_q.cal) begin
            // Recalibration takes the sample straight as the new reference
            s_d.ref_lvl   = raw_i;
            s_d.cal       = 1'b0;
            s_d.integ     = 3'h0;
            s_d.drift_cnt = 6'h00;
         end else if (!s_q.det) begin
            // Integrator: consecutive qualifiers, any miss clears at once
            if (thr_if.qual) begin
               s_d.integ = s_q.integ + 3'h1;
               if (!new_det) begin
                  s_d.wait_ms = BURST_CONF_MS;
               end
            end else begin
               s_d.integ = 3'h0;
            end
            // Drift only while idle; one step per burst down, slower up
            if (raw_i < s_q.ref_lvl) begin
               s_d.ref_lvl   = s_q.ref_lvl - DRIFT_STEP;
               s_d.drift_cnt = 6'h00;
            end else if (raw_i > s_q.ref_lvl && !thr_if.qual) begin
               if (s_q.drift_cnt == DRIFT_UP_BURST - 6'h01) begin
                  s_d.ref_lvl   = s_q.ref_lvl + DRIFT_STEP;
                  s_d.drift_cnt = 6'h00;
               end else begin
                  s_d.drift_cnt = s_q.drift_cnt + 6'h01;
               end
            end
         end
         // No reference change at all while a detection stands
      end

      // Detection start and its effect on the output line
      if (new_det) begin
         s_d.det   = 1'b1;
         s_d.integ = 3'h0;
         s_d.on_ms = 16'h0000;
         case (s_q.mode)
            TD_MODE_TOGGLE: s_d.out_lvl  = ~s_q.out_lvl;
            TD_MODE_PULSE:  s_d.pulse_ms = PULSE_MS;
            default:        s_d.out_lvl  = 1'b1;
         endcase
      end

      // Detection ends by hysteresis dropout
      if (end_det) begin
         s_d.det = 1'b0;
         if (s_q.mode == TD_MODE_DC10 || s_q.mode == TD_MODE_DC60) begin
            s_d.out_lvl = 1'b0;
         end
      end

      // Max on-duration: full recalibration; toggle and pulse keep the line
      if (timeout) begin
         s_d.det   = 1'b0;
         s_d.integ = 3'h0;
         s_d.cal   = 1'b1;
         if (s_q.mode == TD_MODE_DC10 || s_q.mode == TD_MODE_DC60) begin
            s_d.out_lvl = 1'b0;
         end
      end

      // Registered active-low line
      s_d.out_n = ~(s_d.out_lvl | (s_d.pulse_ms != 7'h00));

      // Register writes: only the run bit is writable
      if (wr_i && addr_i == REG_CTRL) begin
         s_d.run = wdata_i[CTRL_RUN_BIT];
      end

      // Read data stands only in the cycle after the strobe
      s_d.rdata = 32'h0000_0000;
      if (rd_i) begin
         case (addr_i)
            REG_CTRL:   s_d.rdata = {31'h0, s_q.run};
            REG_STATUS: s_d.rdata = {16'h0, s_q.mode, s_q.gain, 5'h0, s_q.cal,
                                     s_q.integ, s_q.out_lvl, ~s_q.out_n, s_q.det};
            REG_RAW:    s_d.rdata = {16'h0, s_q.raw};
            REG_REF:    s_d.rdata = {16'h0, s_q.ref_lvl};
            REG_THR:    s_d.rdata = {16'h0, thr_if.thr_lvl};
            default:    s_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   // State register; reset arms recalibration, as does max on-duration expiry
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q          <= '0;
         s_q.st       <= TD_ST_STRAP;
         s_q.cal      <= 1'b1;
         s_q.out_n    <= 1'b1;
         s_q.run      <= CTRL_RUN_RST;
         s_q.mode     <= TD_MODE_DC10;
         s_q.gain     <= GAIN_OPEN;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops
   assign out_n_o  = s_q.out_n;
   assign detect_o = s_q.det;
   assign rdata_o  = s_q.rdata;
endmodule
`default_nettype wire

/* tb/td_conv_model.sv */
// Purpose: Behavioural converter answering each burst request once.
// Assumes: One request outstanding at a time.
// Notes:   Result bus shows the inverted last value between answers.
`default_nettype none
module td_conv_model (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   // Request and level to report
   input  wire logic        burst_req_i,
   input  wire logic [15:0] level_i,
   input  wire logic [7:0]  lat_i,
   // Result
   output logic             raw_valid_o,
   output logic [15:0]      raw_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] cnt_q;

   // Answer lat_i + 1 cycles after the request; stale data inverted so late sampling shows up
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q       <= 9'h000;
         raw_valid_o <= 1'b0;
         raw_o       <= 16'h0000;
      end else begin
         raw_valid_o <= 1'b0;
         if (raw_valid_o) raw_o <= ~raw_o;
         if (burst_req_i) cnt_q <= {1'b0, lat_i} + 9'h001;
         else if (cnt_q != 9'h000) cnt_q <= cnt_q - 9'h001;
         if (cnt_q == 9'h001) begin
            raw_valid_o <= 1'b1;
            raw_o       <= level_i;
         end
      end
   end
endmodule
`default_nettype wire

/* tb/td_core_asserts.sv */
// Purpose: Port-level assertions for the touch detect core.
// Assumes: Straps steady at the first edge after reset.
// Notes:   Max on-duration expiry is not covered here.
`default_nettype none
module td_core_asserts
   import td_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)(
   // Clock, reset, straps
   input wire logic        mclk_i,
   input wire logic        rst_i,
   input wire logic [1:0]  gain_strap_i,
   input wire logic        mode_strap_a_i,
   input wire logic        mode_strap_b_i,
   // Converter and register port
   input wire logic        burst_req_o,
   input wire logic        raw_valid_i,
   input wire logic [15:0] raw_i,
   input wire logic [7:0]  addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rdata_o,
   // Output line
   input wire logic        out_n_o,
   input wire logic        detect_o
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MIN_GAP = 19 * TICK_CYCLES;
   localparam int PLS_MIN = 74 * TICK_CYCLES;
   localparam int PLS_MAX = 76 * TICK_CYCLES + 1;
   logic        cap_q;
   logic        seen_q;
   logic [1:0]  mode_q;
   logic [31:0] gap_q;
   logic [31:0] low_q;

   // Strap copy taken once, like the core; gap and low-time counters
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cap_q  <= 1'b0;
         seen_q <= 1'b0;
         mode_q <= 2'h0;
         gap_q  <= 32'h0;
         low_q  <= 32'h0;
      end else begin
         cap_q  <= 1'b1;
         seen_q <= seen_q | raw_valid_i;
         if (!cap_q) mode_q <= {mode_strap_a_i, mode_strap_b_i};
         gap_q  <= raw_valid_i ? 32'h0 : gap_q + 32'h1;
         low_q  <= out_n_o ? 32'h0 : low_q + 32'h1;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   a_burst_one_cycle: assert property (burst_req_o |=> !burst_req_o)
      else $error("burst request wider than one cycle");
   a_burst_spacing: assert property (burst_req_o && seen_q |-> gap_q >= MIN_GAP)
      else $error("burst request too soon after a result");
   a_detect_on_result: assert property ($rose(detect_o) |-> $past(raw_valid_i))
      else $error("detection rose without a result");
   a_output_on_detect: assert property ($rose(detect_o) |-> !out_n_o || $changed(out_n_o))
      else $error("output ignored a new detection");
   a_level_follows: assert property (mode_q[1] |-> out_n_o == !detect_o)
      else $error("level output differs from detection");
   a_toggle_only: assert property (
      cap_q && mode_q == TD_MODE_TOGGLE && $changed(out_n_o) |-> $rose(detect_o))
      else $error("toggle output moved without a new detection");
   a_pulse_bound: assert property (mode_q == TD_MODE_PULSE |-> low_q <= PLS_MAX)
      else $error("pulse too long");
   a_pulse_length: assert property (
      mode_q == TD_MODE_PULSE && $rose(out_n_o) |-> low_q >= PLS_MIN)
      else $error("pulse too short");
   a_read_idle: assert property (!rd_i |=> rdata_o == 32'h0)
      else $error("read data outside a read");
   a_status_mode: assert property (
      rd_i && cap_q && addr_i == REG_STATUS |=> rdata_o[15:14] == mode_q)
      else $error("mode field differs from power-up straps");
endmodule

bind td_core td_core_asserts #(.TICK_CYCLES(TICK_CYCLES)) td_core_asserts_inst (
   .mclk_i(mclk_i), .rst_i(rst_i), .gain_strap_i(gain_strap_i),
   .mode_strap_a_i(mode_strap_a_i), .mode_strap_b_i(mode_strap_b_i),
   .burst_req_o(burst_req_o), .raw_valid_i(raw_valid_i), .raw_i(raw_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .out_n_o(out_n_o), .detect_o(detect_o));
`default_nettype wire

/* tb/td_core_tb.sv */
// Purpose: Self-checking bench for the touch detect core.
// Assumes: Ms tick shortened to 10 cycles.
// Notes:   Max on-duration is too long to run here.
`default_nettype none
module td_core_tb
   import td_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int T = 10;
   logic        clk, rst, wr, rd, sa, sb, breq, rvld, out_n, det;
   logic [1:0]  gain;
   logic [7:0]  addr, lat;
   logic [15:0] lvl, raw;
   logic [31:0] wdata, rdata, d;
   logic [7:0]  fr [4] = '{FRAC_GAIN_HI, FRAC_GAIN_MED, FRAC_GAIN_LO, FRAC_GAIN_HI};
   int          miscompares, comparisons, n;

   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   td_core #(.TICK_CYCLES(T)) td_core_inst (.mclk_i(clk), .rst_i(rst), .gain_strap_i(gain),
      .mode_strap_a_i(sa), .mode_strap_b_i(sb), .burst_req_o(breq), .raw_valid_i(rvld),
      .raw_i(raw), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .out_n_o(out_n), .detect_o(det));
   td_conv_model td_conv_model_inst (.mclk_i(clk), .rst_i(rst), .burst_req_i(breq),
      .level_i(lvl), .lat_i(lat), .raw_valid_o(rvld), .raw_o(raw));

   task automatic test_done();
      if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi);
      comparisons++;
      if (got < lo || got > hi) begin
         miscompares++;
         $display("wrong value at %0t: spacing %0d", $time, got);
      end
   endtask

   // Register port: one-cycle strobes, read data in the following cycle
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   // Bounded wait for the next result; returns the cycles waited
   task automatic wait_res(output int g);
      g = 0;
      do begin
         @(posedge clk);
         g++;
      end while (rvld !== 1'b1 && g < 80 * T);
      if (rvld !== 1'b1) begin
         miscompares++;
         test_done();
      end
      #1;
   endtask

   task automatic res(input int k);
      repeat (k) wait_res(n);
   endtask

   // Supply cycle recalibrates (as does max on-duration expiry) and is the only way to re-read straps
   task automatic power(input logic [1:0] g, input logic a, input logic b);
      @(posedge clk);
      rst <= 1'b1;
      gain <= g;
      sa <= a;
      sb <= b;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      res(1);
   endtask

   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      gain = 2'h0;
      sa = 1'b1;
      sb = 1'b1;
      lvl = 16'h03e8;
      lat = 8'h00;
      miscompares = 0;
      comparisons = 0;
      // Each gain strap code sets its threshold above the calibrated level; codes 0 and 3 share one
      for (int i = 3; i >= 0; i--) begin
         power(2'(i), 1'b1, 1'b1);
         rd_reg(REG_REF, d);
         chk(d, 32'h3e8);
         rd_reg(REG_THR, d);
         chk(d, 32'h3e8 + ((32'h3e8 * fr[i]) >> 8));
      end
      // Three qualifiers then a miss restarts the count
      lvl <= 16'h044c;
      wait_res(n);
      chk_rng(n, 74 * T, 76 * T + 3);
      wait_res(n);
      chk_rng(n, 19 * T, 21 * T + 3);
      wait_res(n);
      lvl <= 16'h03e8;
      wait_res(n);
      chk({out_n, det}, 32'h2);
      lvl <= 16'h044c;
      res(3);
      chk({out_n, det}, 32'h2);
      wait_res(n);
      chk({out_n, det}, 32'h1);
      rd_reg(REG_STATUS, d);
      chk(d, 32'h0000_c007);
      rd_reg(REG_RAW, d);
      chk(d, 32'h44c);
      // Between hysteresis and threshold the detection holds, reference frozen
      lvl <= 16'h03f2;
      res(2);
      chk(det, 32'h1);
      rd_reg(REG_REF, d);
      chk(d, 32'h3e8);
      lvl <= 16'h03ed;
      wait_res(n);
      chk({out_n, det}, 32'h2);
      // Fast fall, slow rise of the reference, threshold following it
      lvl <= 16'h03de;
      res(3);
      rd_reg(REG_REF, d);
      chk(d, 32'h3e5);
      lvl <= 16'h03ed;
      res(15);
      rd_reg(REG_REF, d);
      chk(d, 32'h3e5);
      res(1);
      rd_reg(REG_REF, d);
      chk(d, 32'h3e6);
      rd_reg(REG_THR, d);
      chk(d, 32'h3e6 + ((32'h3e6 * FRAC_GAIN_HI) >> 8));
      // Unmapped read, read-only write, late strap change, run stop
      rd_reg(8'h20, d);
      chk(d, 32'h0);
      wr_reg(REG_REF, 32'h1234);
      gain <= 2'h2;
      rd_reg(REG_REF, d);
      chk(d, 32'h3e6);
      wait_res(n);
      rd_reg(REG_THR, d);
      chk(d, 32'h3e6 + ((32'h3e6 * FRAC_GAIN_HI) >> 8));
      wr_reg(REG_CTRL, 32'h0);
      n = 0;
      repeat (80 * T) @(posedge clk) n += int'(breq);
      chk(n, 0);
      wr_reg(REG_CTRL, 32'h1);
      // Toggle mode with a slow converter
      lvl <= 16'h03e8;
      lat <= 8'h25;
      power(2'h0, 1'b0, 1'b0);
      lvl <= 16'h044c;
      res(4);
      chk(out_n, 32'h0);
      lvl <= 16'h03e8;
      res(1);
      chk({out_n, det}, 32'h0);
      lvl <= 16'h044c;
      res(4);
      chk({out_n, det}, 32'h3);
      // Long level mode: line follows the detection, mode field from straps
      lvl <= 16'h03e8;
      power(2'h0, 1'b1, 1'b0);
      rd_reg(REG_STATUS, d);
      chk({30'h0, d[15:14]}, 32'h2);
      lvl <= 16'h044c;
      res(4);
      chk({out_n, det}, 32'h1);
      lvl <= 16'h03e8;
      res(1);
      chk({out_n, det}, 32'h2);
      // Pulse mode: one low pulse per new detection
      lvl <= 16'h03e8;
      power(2'h0, 1'b0, 1'b1);
      lvl <= 16'h044c;
      res(4);
      chk({out_n, det}, 32'h1);
      repeat (74 * T) @(posedge clk);
      chk(out_n, 32'h0);
      repeat (3 * T) @(posedge clk);
      chk(out_n, 32'h1);
      test_done();
   end
endmodule
`default_nettype wire
